// ===== sps_port.sv
// sps_port: spi master/slave port with buffer, control and state registers.
// assumes: apb master on core_clk; pins resolved outside from the enables.
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/10ps
module sps_port
  import sps_pkg::*;
#(
  parameter int DATA_W = 8
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial pins
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe,
  input wire logic ss_n_i,
  // system
  input wire logic timer_two_output,
  input wire logic sleep_halt,
  output logic port_interrupt_flag
);

  if (DATA_W < 2 || DATA_W > 8)
  begin : g_chk
    $error("sps_port: DATA_W must be 2..8");
  end

  localparam logic [5:0] LAST = 6'(2 * DATA_W - 1);
  localparam logic [4:0] CNT_LAST = 5'(DATA_W - 1);

  function automatic logic [5:0] half_count(input logic [3:0] m);
    case (m)
      SPS_MODE_DIV16: half_count = SPS_HALF_DIV16;
      SPS_MODE_DIV64: half_count = SPS_HALF_DIV64;
      default: half_count = SPS_HALF_DIV4;
    endcase
  endfunction : half_count

  // ==========================================================
  // registers
  sps_ctrl_s ctrl_r;
  logic smp_r, cke_r, bf_r, flag_r;
  logic [1:0] pindir_r;
  logic [DATA_W-1:0] buf_r, tx_r, rx_r;
  logic run_r, sck_r, sdo_r, sck_lvl_r;
  logic [5:0] half_r, div_r;
  logic [4:0] cnt_r;
  logic [31:0] prdata_r;
  sps_pins_s pins;

  // ==========================================================
  // pin synchronisers
  sps_pin_sync #(.W(3), .RST_VAL(3'h1)) sps_pin_sync_inst (
    .core_clk(core_clk),
    .nrst(nrst),
    .pin_in({sck_i, sdi_i, ss_n_i}),
    .level_out(pins)
  );

  // ==========================================================
  // mode decode
  wire en = ctrl_r.en;
  wire is_master = en && (ctrl_r.mode <= SPS_MODE_TMR);
  wire is_timer = ctrl_r.mode == SPS_MODE_TMR;
  wire is_slave = en && (ctrl_r.mode == SPS_MODE_SLV_SS || ctrl_r.mode == SPS_MODE_SLV);
  wire ss_mode = ctrl_r.mode == SPS_MODE_SLV_SS;
  wire ss_hi = ss_mode && pins.ss_n;
  wire sdo_in = pindir_r[SPS_PIN_SDO_IN];
  wire busy = run_r || (cnt_r != 5'h00);

  // ==========================================================
  // apb decode; zero wait states, read data captured in setup
  wire setup = psel && !penable;
  wire access = psel && penable;
  wire hit_buf = paddr == SPS_OFF_BUF;
  wire hit_ctrl = paddr == SPS_OFF_CTRL;
  wire hit_state = paddr == SPS_OFF_STATE;
  wire hit_pin = paddr == SPS_OFF_PINDIR;
  wire hit_evt = paddr == SPS_OFF_EVENT;
  wire hit_any = hit_buf || hit_ctrl || hit_state || hit_pin || hit_evt;
  wire wr = access && pwrite && pstrb[0];
  wire rd = access && !pwrite;
  wire wr_buf = wr && hit_buf;
  wire rd_buf = rd && hit_buf;
  wire load = wr_buf && en && !busy && !ss_hi;
  wire collide = wr_buf && en && busy;
  wire [DATA_W-1:0] wdat = pwdata[DATA_W-1:0];

  assign pready = 1'b1;
  assign pslverr = access && !hit_any;
  assign prdata = prdata_r;

  wire [7:0] state_rd = {smp_r, cke_r, 5'h00, bf_r};
  wire [31:0] rd_mux = hit_buf ? 32'(buf_r) :
                       hit_ctrl ? {24'h000000, ctrl_r} :
                       hit_state ? {24'h000000, state_rd} :
                       hit_pin ? {30'h00000000, pindir_r} :
                       hit_evt ? {31'h00000000, flag_r} : 32'h00000000;

  // ==========================================================
  // master clock engine
  wire div_hit = div_r == half_count(ctrl_r.mode) - 6'h01;
  wire m_tick = run_r && !sleep_halt && (is_timer ? timer_two_output : div_hit);
  wire m_cap = smp_r ? (cke_r ? half_r[0] : (!half_r[0] && half_r != 6'h00) || half_r == LAST)
                     : (cke_r ? !half_r[0] : half_r[0]);
  wire m_drv = cke_r ? (half_r[0] && half_r != LAST) : !half_r[0];
  wire m_done = m_tick && half_r == LAST;

  // ==========================================================
  // slave edge detect on filtered clock
  wire s_go = is_slave && !ss_hi;
  wire s_edge = s_go && (pins.sck != sck_lvl_r);
  wire s_lead = s_edge && (pins.sck != ctrl_r.clock_idle_polarity);
  wire s_trail = s_edge && (pins.sck == ctrl_r.clock_idle_polarity);
  wire s_cap = cke_r ? s_lead : s_trail;
  wire s_drv = cke_r ? s_trail : s_lead;
  wire s_done = s_cap && cnt_r == CNT_LAST;

  // ==========================================================
  // shared shifters
  wire do_cap = (m_tick && m_cap) || s_cap;
  wire do_drv = (m_tick && m_drv) || s_drv;
  wire [DATA_W-1:0] rx_nxt = do_cap ? {rx_r[DATA_W-2:0], pins.sdi} : rx_r;
  wire byte_done = m_done || s_done;
  wire ovf_set = s_done && bf_r && !rd_buf;
  wire take = byte_done && !ovf_set;

  // pins; select release follows the filtered level
  assign sck_o = sck_r;
  assign sck_oe = is_master && !pindir_r[SPS_PIN_SCK_IN];
  assign sdo_o = sdo_r;
  assign sdo_oe = (is_master || s_go) && !sdo_in;
  assign port_interrupt_flag = flag_r;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      prdata_r <= 32'h00000000;
    else if (setup)
      prdata_r <= rd_mux;
  end

  // control, state and direction registers; hardware set wins over clear
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_r <= SPS_CTRL_RST;
      smp_r <= SPS_STATE_RST[SPS_STATE_SMP];
      cke_r <= SPS_STATE_RST[SPS_STATE_CKE];
      pindir_r <= SPS_PINDIR_RST;
    end
    else
    begin
      if (wr && hit_ctrl)
      begin
        ctrl_r.en <= pwdata[5];
        ctrl_r.clock_idle_polarity <= pwdata[4];
        ctrl_r.mode <= pwdata[3:0];
        ctrl_r.write_collision_flag <= (ctrl_r.write_collision_flag && pwdata[7]) || collide;
        ctrl_r.ovf <= (ctrl_r.ovf && pwdata[6]) || ovf_set;
      end
      else
      begin
        ctrl_r.write_collision_flag <= ctrl_r.write_collision_flag || collide;
        ctrl_r.ovf <= ctrl_r.ovf || ovf_set;
      end
      if (wr && hit_state)
      begin
        smp_r <= pwdata[SPS_STATE_SMP];
        cke_r <= pwdata[SPS_STATE_CKE];
      end
      if (wr && hit_pin)
        pindir_r <= pwdata[1:0];
    end
  end

  // buffer, full and event flags
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      buf_r <= '0;
      bf_r <= 1'b0;
      flag_r <= 1'b0;
    end
    else
    begin
      if (load)
        buf_r <= wdat;
      else if (take)
        buf_r <= rx_nxt;
      bf_r <= take || (bf_r && !rd_buf);
      flag_r <= byte_done || (flag_r && !(wr && hit_evt && pwdata[SPS_EVT_FLAG]));
    end
  end

  // master sequencer; a sleeping clock freezes every count
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      run_r <= 1'b0;
      half_r <= 6'h00;
      div_r <= 6'h00;
      sck_r <= 1'b0;
    end
    else if (!is_master)
    begin
      run_r <= 1'b0;
      half_r <= 6'h00;
      div_r <= 6'h00;
      sck_r <= (wr && hit_ctrl) ? pwdata[4] : ctrl_r.clock_idle_polarity;
    end
    else if (load || (!run_r && sdo_in))
    begin
      run_r <= 1'b1;
      half_r <= 6'h00;
      div_r <= 6'h00;
      sck_r <= ctrl_r.clock_idle_polarity;
    end
    else if (m_tick)
    begin
      sck_r <= !sck_r;
      half_r <= half_r + 6'h01;
      div_r <= 6'h00;
      if (m_done)
        run_r <= 1'b0;
    end
    else if (run_r && !sleep_halt && !is_timer)
      div_r <= div_r + 6'h01;
    else if (!run_r)
      sck_r <= ctrl_r.clock_idle_polarity;
  end

  // shifters and slave bit counter
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tx_r <= '0;
      rx_r <= '0;
      sdo_r <= 1'b0;
      cnt_r <= 5'h00;
      sck_lvl_r <= 1'b0;
    end
    else
    begin
      sck_lvl_r <= pins.sck;
      rx_r <= rx_nxt;
      if (load)
      begin
        sdo_r <= wdat[DATA_W-1];
        tx_r <= cke_r ? {wdat[DATA_W-2:0], 1'b0} : wdat;
      end
      else if (do_drv)
      begin
        sdo_r <= tx_r[DATA_W-1];
        tx_r <= {tx_r[DATA_W-2:0], 1'b0};
      end
      if (!is_slave || ss_hi)
        cnt_r <= 5'h00;
      else if (s_done)
        cnt_r <= 5'h00;
      else if (s_cap)
        cnt_r <= cnt_r + 5'h01;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  property p_collide;
    collide |=> ctrl_r.write_collision_flag;
  endproperty
  a_collide: assert property (p_collide) else $error("collision flag not set");

  property p_disable;
    !en |-> (!sdo_oe && !sck_oe) ##1 (!run_r && cnt_r == 5'h00);
  endproperty
  a_disable: assert property (p_disable) else $error("port active while disabled");

  property p_start;
    load && is_master |=> run_r && half_r == 6'h00;
  endproperty
  a_start: assert property (p_start) else $error("master write did not start");

  property p_msb;
    load |=> sdo_r == $past(pwdata[DATA_W-1]);
  endproperty
  a_msb: assert property (p_msb) else $error("first bit is not the msb");

  property p_ss_release;
    ss_hi |-> !sdo_oe;
  endproperty
  a_ss_release: assert property (p_ss_release) else $error("data out driven with select high");

  property p_ss_reset;
    is_slave && ss_hi |=> cnt_r == 5'h00;
  endproperty
  a_ss_reset: assert property (p_ss_reset) else $error("bit counter not cleared");

  property p_sdo_in;
    sdo_in |-> !sdo_oe;
  endproperty
  a_sdo_in: assert property (p_sdo_in) else $error("data out driven while input");

  property p_freeze;
    run_r && sleep_halt && is_master |=> $stable(half_r) && $stable(sck_r);
  endproperty
  a_freeze: assert property (p_freeze) else $error("transfer moved during sleep");

  property p_done_flag;
    byte_done |=> flag_r && (bf_r || ctrl_r.ovf);
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("byte completion not flagged");

  property p_div4;
    (ctrl_r.mode == SPS_MODE_DIV4 && m_tick && half_r != LAST) ##1
      (run_r && !sleep_halt && ctrl_r.mode == SPS_MODE_DIV4)[*2] |-> m_tick;
  endproperty
  a_div4: assert property (p_div4) else $error("divide by four rate wrong");

  property p_idle;
    !run_r && $past(!run_r) && is_master |-> sck_r == ctrl_r.clock_idle_polarity;
  endproperty
  a_idle: assert property (p_idle) else $error("serial clock not idle");

  c_master_done: cover property (m_done);
  c_slave_done: cover property (s_done);
  c_collide: cover property (collide);
  c_overflow: cover property (ovf_set);

endmodule : sps_port

// ===== sps_pkg.sv
// sps_pkg: constants, register map and field layouts of the serial port.
// assumes: one 250 MHz core clock; registers reached over APB, one word each.
package sps_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [11:0] SPS_OFF_BUF = 12'h000;
  localparam logic [11:0] SPS_OFF_CTRL = 12'h004;
  localparam logic [11:0] SPS_OFF_STATE = 12'h008;
  localparam logic [11:0] SPS_OFF_PINDIR = 12'h00C;
  localparam logic [11:0] SPS_OFF_EVENT = 12'h010;

  // ==========================================================
  // field positions
  localparam int SPS_STATE_SMP = 7;
  localparam int SPS_STATE_CKE = 6;
  localparam int SPS_STATE_BF = 0;
  localparam int SPS_PIN_SDO_IN = 0;
  localparam int SPS_PIN_SCK_IN = 1;
  localparam int SPS_EVT_FLAG = 0;

  // ==========================================================
  // reset values
  localparam logic [7:0] SPS_CTRL_RST = 8'h00;
  localparam logic [7:0] SPS_STATE_RST = 8'h00;
  localparam logic [1:0] SPS_PINDIR_RST = 2'h3;

  // ==========================================================
  // mode field codes
  localparam logic [3:0] SPS_MODE_DIV4 = 4'h0;
  localparam logic [3:0] SPS_MODE_DIV16 = 4'h1;
  localparam logic [3:0] SPS_MODE_DIV64 = 4'h2;
  localparam logic [3:0] SPS_MODE_TMR = 4'h3;
  localparam logic [3:0] SPS_MODE_SLV_SS = 4'h4;
  localparam logic [3:0] SPS_MODE_SLV = 4'h5;

  // ==========================================================
  // timing: core cycles per half serial clock period, and pin synchroniser stage count
  localparam logic [5:0] SPS_HALF_DIV4 = 6'h02;
  localparam logic [5:0] SPS_HALF_DIV16 = 6'h08;
  localparam logic [5:0] SPS_HALF_DIV64 = 6'h20;
  localparam int SPS_SYNC_STAGES = 3;

  // control register layout, bit 7 first
  typedef struct packed {
    logic write_collision_flag;
    logic ovf;
    logic en;
    logic clock_idle_polarity;
    logic [3:0] mode;
  } sps_ctrl_s;

  // synchronised pin levels
  typedef struct packed {
    logic sck;
    logic sdi;
    logic ss_n;
  } sps_pins_s;

endpackage : sps_pkg

// ===== sps_pin_sync.sv
// sps_pin_sync: three-stage synchroniser with agreement filter for pins.
// assumes: inputs are asynchronous to core_clk.
`timescale 1ns/10ps
module sps_pin_sync
  import sps_pkg::*;
#(
  parameter int W = 3,
  parameter logic [W-1:0] RST_VAL = '0
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // pins and filtered levels
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level_out
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // a change counts only once stages two and three agree
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
      level_out <= RST_VAL;
    end
    else
    begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < W; i++)
      begin
        if (s2_r[i] == s3_r[i])
          level_out[i] <= s3_r[i];
      end
    end
  end

endmodule : sps_pin_sync

// ===== sps_far_end.sv
// sps_far_end: peer spi controller for the bench, slave or master role.
// assumes: bench resolves the lines; core_clk paces the master role only.
`timescale 1ns/10ps
module sps_far_end
(
  // pacing clock
  input wire logic core_clk,
  // settings
  input wire logic clock_idle_polarity,
  input wire logic [7:0] tx_byte,
  // serial lines
  input wire logic sck_line,
  input wire logic sdo_line,
  output logic sck_out,
  output logic sdi_line,
  output logic ss_n,
  output logic [7:0] rx_byte
);
  logic drv = 1'b0;
  logic sck_r = 1'b0;
  logic [7:0] sh;
  int cnt;

  initial
  begin
    ss_n = 1'b1;
    sdi_line = 1'b0;
    rx_byte = 8'h00;
  end

  // clock rests at the idle level outside frames
  assign sck_out = drv ? sck_r : clock_idle_polarity;

  // ==========
  // slave role, edge select set
  task automatic arm;
    cnt = 0;
    sdi_line <= tx_byte[7];
  endtask : arm

  always @(sck_line)
    if (!drv && sck_line != clock_idle_polarity)
    begin
      rx_byte = {rx_byte[6:0], sdo_line};
      cnt++;
    end
    else if (!drv)
    begin
      if (cnt >= 8)
        cnt = 0;
      sdi_line = tx_byte[7 - cnt];
    end

  // ==========
  // master role; edge select picks the capturing edge
  task automatic step(input logic cap);
    if (cap)
      rx_byte <= {rx_byte[6:0], sdo_line};
    else
    begin
      sdi_line <= sh[7];
      sh = sh << 1;
    end
  endtask : step

  task automatic master_byte(input int half, input int nb, input logic cke, input logic sel);
    int k;
    sh = tx_byte;
    ss_n <= !sel;
    drv <= 1'b1;
    sck_r <= clock_idle_polarity;
    if (cke)
      step(1'b0);
    repeat (half) @(posedge core_clk);
    for (k = 0; k < nb; k++)
    begin
      sck_r <= ~clock_idle_polarity;
      step(cke);
      repeat (half) @(posedge core_clk);
      sck_r <= clock_idle_polarity;
      step(!cke);
      repeat (half) @(posedge core_clk);
    end
    // released line must not keep showing the last bit
    ss_n <= 1'b1;
    drv <= 1'b0;
    sdi_line <= ~sdi_line;
  endtask : master_byte
endmodule : sps_far_end

// ===== sps_port_tb.sv
// sps_port_tb: apb-driven self-check of the serial port against a peer.
// assumes: package, sps_port and sps_far_end compiled before this file.
`timescale 1ns/10ps
module sps_port_tb;
  import sps_pkg::*;
  logic core_clk = 1'b0;
  logic nrst, psel, penable, pwrite, timer_two_output, sleep_halt, pready, pslverr, err;
  logic sck_o, sck_oe, sdo_o, sdo_oe, flag, sck_p, far_sck, sdi, ss_n, clock_idle_polarity;
  logic sdo_last = 1'b0;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [7:0] far_tx, far_rx;
  logic [5:0] halves [4] = '{SPS_HALF_DIV4, SPS_HALF_DIV16, SPS_HALF_DIV64, 6'h06};
  int n_fail, comparisons, cyc, toggles, since, gap, tcnt, i, t0, tb;
  wire logic sck_w = sck_oe ? sck_o : far_sck;
  // undriven data line flips every cycle so a stale sample shows
  wire logic sdo_w = sdo_oe ? sdo_o : ~sdo_last;

  always #2 core_clk = ~core_clk;

  sps_port sps_port_inst (
    .core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sck_i(sck_w), .sck_o(sck_o), .sck_oe(sck_oe), .sdi_i(sdi),
    .sdo_o(sdo_o), .sdo_oe(sdo_oe), .ss_n_i(ss_n), .timer_two_output(timer_two_output),
    .sleep_halt(sleep_halt), .port_interrupt_flag(flag));

  sps_far_end sps_far_end_inst (
    .core_clk(core_clk), .clock_idle_polarity(clock_idle_polarity), .tx_byte(far_tx), .sck_line(sck_w), .sdo_line(sdo_w),
    .sck_out(far_sck), .sdi_line(sdi), .ss_n(ss_n), .rx_byte(far_rx));

  // ==========
  // timer pulses every 6 cycles, clock edge monitor, hang guard
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    tcnt <= (tcnt == 5) ? 0 : tcnt + 1;
    timer_two_output <= (tcnt == 5);
    sdo_last <= sdo_w;
    sck_p <= sck_w;
    since <= (sck_w !== sck_p) ? 1 : since + 1;
    if (sck_w !== sck_p)
      toggles <= toggles + 1;
    if (sck_w !== sck_p)
      gap <= since;
    if (cyc == 20000)
    begin
      n_fail++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1)
      @(posedge core_clk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_flag;
    int k;
    q = 32'h0;
    for (k = 0; k < 700 && q[0] !== 1'b1; k++)
      apb(1'b0, SPS_OFF_EVENT, 32'h0);
    chk({q[31:1], flag}, 32'h1);
    apb(1'b1, SPS_OFF_EVENT, 32'h1);
  endtask : wait_flag

  task automatic final_report;
    if (n_fail == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  // ==========
  initial
  begin
    {nrst, psel, penable, pwrite, sleep_halt, clock_idle_polarity} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    far_tx = 8'h00;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    apb(1'b0, SPS_OFF_CTRL, 32'h0);
    chk(q, {24'h0, SPS_CTRL_RST});
    apb(1'b0, SPS_OFF_STATE, 32'h0);
    chk(q, {24'h0, SPS_STATE_RST});
    apb(1'b0, SPS_OFF_PINDIR, 32'h0);
    chk(q, {30'h0, SPS_PINDIR_RST});
    apb(1'b0, 12'h014, 32'h0);
    chk({q[30:0], err}, 32'h1);
    // disabled port must not start on a buffer write
    apb(1'b1, SPS_OFF_PINDIR, 32'h0);
    apb(1'b1, SPS_OFF_BUF, 32'h55);
    tb = toggles;
    repeat (40) @(posedge core_clk);
    chk(toggles - tb, 0);
    apb(1'b1, SPS_OFF_STATE, 32'h40);
    for (i = 0; i < 4; i++)
    begin
      clock_idle_polarity = i[0];
      far_tx = 8'hA5 ^ 8'(i);
      apb(1'b1, SPS_OFF_CTRL, 32'h0);
      apb(1'b1, SPS_OFF_CTRL, {26'h0, 1'b1, clock_idle_polarity, 4'(i)});
      sps_far_end_inst.arm();
      tb = toggles;
      apb(1'b1, SPS_OFF_BUF, {24'h0, ~far_tx});
      @(negedge core_clk);
      chk({30'h0, sdo_w, sck_w}, {30'h0, ~far_tx[7], clock_idle_polarity});
      apb(1'b1, SPS_OFF_BUF, 32'hFF);
      if (i == 1)
      begin
        sleep_halt <= 1'b1;
        repeat (3) @(posedge core_clk);
        t0 = toggles;
        repeat (40) @(posedge core_clk);
        chk(toggles, t0);
        sleep_halt <= 1'b0;
      end
      wait_flag();
      chk(toggles - tb, 16);
      chk(gap, {26'h0, halves[i]});
      chk({24'h0, far_rx}, {24'h0, ~far_tx});
      apb(1'b0, SPS_OFF_STATE, 32'h0);
      chk(q & 32'h1, 32'h1);
      apb(1'b0, SPS_OFF_CTRL, 32'h0);
      chk(q & 32'h80, 32'h80);
      apb(1'b0, SPS_OFF_BUF, 32'h0);
      // at the fastest rate the sync delay eats the far end's setup
      if (i != 0)
        chk(q, {24'h0, far_tx});
      apb(1'b0, SPS_OFF_STATE, 32'h0);
      chk(q & 32'h1, 32'h0);
    end
    // receive-only master keeps clocking
    apb(1'b1, SPS_OFF_CTRL, 32'h0);
    apb(1'b1, SPS_OFF_PINDIR, 32'h1);
    sps_far_end_inst.arm();
    apb(1'b1, SPS_OFF_CTRL, 32'h31);
    apb(1'b1, SPS_OFF_BUF, 32'h0);
    wait_flag();
    chk({31'h0, sdo_oe}, 32'h0);
    apb(1'b0, SPS_OFF_BUF, 32'h0);
    chk(q, {24'h0, far_tx});
    // slave with select, edge select set
    clock_idle_polarity = 1'b0;
    apb(1'b1, SPS_OFF_CTRL, 32'h0);
    apb(1'b1, SPS_OFF_PINDIR, 32'h2);
    apb(1'b1, SPS_OFF_CTRL, 32'h24);
    far_tx = 8'hFF;
    fork
      sps_far_end_inst.master_byte(8, 3, 1'b1, 1'b1);
      begin
        repeat (12) @(posedge core_clk);
        chk({31'h0, sdo_oe}, 32'h1);
      end
    join
    repeat (6) @(posedge core_clk);
    chk({31'h0, sdo_oe}, 32'h0);
    far_tx = 8'h96;
    sps_far_end_inst.master_byte(8, 8, 1'b1, 1'b1);
    wait_flag();
    apb(1'b0, SPS_OFF_BUF, 32'h0);
    chk(q, 32'h96);
    // slave without select, edge select clear
    apb(1'b1, SPS_OFF_CTRL, 32'h0);
    apb(1'b1, SPS_OFF_STATE, 32'h0);
    apb(1'b1, SPS_OFF_CTRL, 32'h25);
    apb(1'b1, SPS_OFF_BUF, 32'h5A);
    far_tx = 8'h3E;
    sps_far_end_inst.master_byte(8, 8, 1'b0, 1'b0);
    wait_flag();
    chk({24'h0, far_rx}, 32'h5A);
    // buffer left unread: the next byte overflows and is lost
    far_tx = 8'h11;
    sps_far_end_inst.master_byte(8, 8, 1'b0, 1'b0);
    wait_flag();
    apb(1'b0, SPS_OFF_CTRL, 32'h0);
    chk(q & 32'h40, 32'h40);
    apb(1'b0, SPS_OFF_BUF, 32'h0);
    chk(q, 32'h3E);
    // reset in mid-transfer
    apb(1'b1, SPS_OFF_CTRL, 32'h0);
    apb(1'b1, SPS_OFF_PINDIR, 32'h0);
    apb(1'b1, SPS_OFF_CTRL, 32'h21);
    apb(1'b1, SPS_OFF_BUF, 32'hC3);
    repeat (20) @(posedge core_clk);
    nrst <= 1'b0;
    @(negedge core_clk);
    chk({30'h0, sck_oe, sdo_oe}, 32'h0);
    @(posedge core_clk);
    nrst <= 1'b1;
    apb(1'b0, SPS_OFF_CTRL, 32'h0);
    chk(q, 32'h0);
    final_report();
  end
endmodule : sps_port_tb
